// [core/gpef_params.svh]
`ifndef GPEF_PARAMS_SVH
`define GPEF_PARAMS_SVH

// ==========================================================================
// register map
`define GPEF_ADDR_W        8
`define GPEF_OFF_PE_LATCH  8'h00
`define GPEF_OFF_PE_DIR    8'h04
`define GPEF_OFF_PF_LATCH  8'h08
`define GPEF_OFF_PF_DIR    8'h0c
`define GPEF_OFF_STANDBY   8'h10
`define GPEF_OFF_LCD_SEL   8'h14
`define GPEF_OFF_STATUS    8'h18
`define GPEF_OFF_PE_RMW    8'h20
`define GPEF_OFF_PF_RMW    8'h28

// ==========================================================================
// fields and reset values
`define GPEF_PE_W          8
`define GPEF_PF_W          3
`define GPEF_PF_RST_BIT    2
`define GPEF_SPL_BIT       0
`define GPEF_PORT_INPUT_CONTROL_BIT     8
`define GPEF_STS_STBY_BIT  11
`define GPEF_RST_LATCH_E   8'h00
`define GPEF_RST_LATCH_F   3'h0
`define GPEF_RST_DIR_E     8'h00
`define GPEF_RST_DIR_F     3'h0
`define GPEF_RST_SEG       8'h00

// ==========================================================================
// bus responses
`define GPEF_RESP_OKAY     2'h0
`define GPEF_RESP_SLVERR   2'h2

`endif

// [core/gpef_pkg.sv]
package gpef_pkg;
  typedef enum logic {
    GPEF_WS_IDLE,
    GPEF_WS_RESP
  } gpef_wstate_t;
  typedef logic [7:0] gpef_byte_t;
endpackage

// [core/gpef_sync.sv]
`timescale 1ns/1ps
module gpef_sync #(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // ========================================================================
  // two-stage synchroniser
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

// [core/gpef_pin_cell.sv]
`timescale 1ns/1ps
module gpef_pin_cell #(
  parameter bit OPEN_DRAIN = 1'b0
) (
  input  wire logic dir,
  input  wire logic latch,
  input  wire logic periph_oe,
  input  wire logic periph_out,
  input  wire logic seg_en,
  input  wire logic seg_out,
  input  wire logic claim,
  input  wire logic in_block,
  input  wire logic isolate,
  input  wire logic pin_in,
  input  wire logic read_modify_write,
  output logic      pin_o,
  output logic      pin_oe,
  output logic      rd
);
  logic pin_v;

  // ========================================================================
  // drive and read selection
  always_comb begin
    pin_o  = 1'b0;
    pin_oe = 1'b0;
    pin_v  = (isolate || in_block) ? 1'b0 : pin_in;
    if (isolate) begin
      pin_oe = 1'b0;
    end else if (claim) begin
      pin_oe = 1'b0;
    end else if (seg_en) begin
      pin_o  = seg_out;
      pin_oe = 1'b1;
    end else if (periph_oe) begin
      pin_o  = periph_out;
      pin_oe = 1'b1;
    end else if (dir) begin
      pin_o  = latch;
      pin_oe = !(OPEN_DRAIN && latch);
    end else begin
      pin_oe = 1'b0;
    end
    if (read_modify_write) begin
      rd = latch;
    end else if (dir && !periph_oe && !seg_en && !claim) begin
      rd = latch;
    end else begin
      rd = pin_v;
    end
  end
endmodule

// [core/gpef_port.sv]
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "gpef_params.svh"
module gpef_port #(
  parameter logic [2:0] PF_OPEN_DRAIN  = 3'h4,
  parameter bit         PF2_RESET_ONLY = 1'b0
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [`GPEF_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [`GPEF_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      standby_req,
  input  wire gpef_pkg::gpef_byte_t      periph_oe_e,
  input  wire gpef_pkg::gpef_byte_t      periph_out_e,
  input  wire gpef_pkg::gpef_byte_t      lcd_seg_out,
  input  wire logic                      main_osc_en,
  input  wire logic [`GPEF_PE_W-1:0]     pe_i,
  output logic      [`GPEF_PE_W-1:0]     pe_o,
  output logic      [`GPEF_PE_W-1:0]     pe_oe,
  input  wire logic [`GPEF_PF_W-1:0]     pf_i,
  output logic      [`GPEF_PF_W-1:0]     pf_o,
  output logic      [`GPEF_PF_W-1:0]     pf_oe
);
  import gpef_pkg::*;

  localparam int NP = `GPEF_PE_W + `GPEF_PF_W;
  localparam logic [NP-1:0] OD_ALL = {PF_OPEN_DRAIN, {`GPEF_PE_W{1'b0}}};

  // ========================================================================
  // state
  gpef_wstate_t           wst_r;
  gpef_wstate_t           wst_nxt;
  logic                   aw_held_r;
  logic                   aw_held_nxt;
  logic                   w_held_r;
  logic                   w_held_nxt;
  logic [`GPEF_ADDR_W-1:0] waddr_r;
  logic [`GPEF_ADDR_W-1:0] waddr_nxt;
  logic [31:0]            wdata_r;
  logic [31:0]            wdata_nxt;
  logic [1:0]             wstb_r;
  logic [1:0]             wstb_nxt;
  logic [1:0]             bresp_r;
  logic [1:0]             bresp_nxt;
  logic                   rvalid_r;
  logic                   rvalid_nxt;
  logic [31:0]            rdata_r;
  logic [31:0]            rdata_nxt;
  logic [1:0]             rresp_r;
  logic [1:0]             rresp_nxt;
  gpef_byte_t             pe_latch_r;
  gpef_byte_t             pe_latch_nxt;
  gpef_byte_t             pe_dir_r;
  gpef_byte_t             pe_dir_nxt;
  logic [`GPEF_PF_W-1:0]  pf_latch_r;
  logic [`GPEF_PF_W-1:0]  pf_latch_nxt;
  logic [`GPEF_PF_W-1:0]  pf_dir_r;
  logic [`GPEF_PF_W-1:0]  pf_dir_nxt;
  logic                   spl_r;
  logic                   spl_nxt;
  gpef_byte_t             seg_sel_r;
  gpef_byte_t             seg_sel_nxt;
  logic                   port_input_control_r;
  logic                   port_input_control_nxt;
  logic [NP-1:0]          pin_o_r;
  logic [NP-1:0]          pin_o_nxt;
  logic [NP-1:0]          pin_oe_r;
  logic [NP-1:0]          pin_oe_nxt;

  // ========================================================================
  // pin cells
  logic [NP-1:0]          pin_sync;
  logic [NP-1:0]          cell_o;
  logic [NP-1:0]          cell_oe;
  logic [NP-1:0]          cell_rd;
  logic                   rmw_rd;
  logic [NP-1:0]          dir_all;
  logic [NP-1:0]          latch_all;
  logic [NP-1:0]          poe_all;
  logic [NP-1:0]          pout_all;
  logic [NP-1:0]          seg_all;
  logic [NP-1:0]          segv_all;
  logic [NP-1:0]          claim_all;
  logic [NP-1:0]          blk_all;
  logic                   isolate;
  logic                   hold;

  gpef_sync #(
    .W (NP)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({pf_i, pe_i}),
    .q       (pin_sync)
  );

  assign isolate = standby_req && spl_r;
  assign hold    = standby_req && !spl_r;

  always_comb begin
    dir_all   = {pf_dir_r, pe_dir_r};
    latch_all = {pf_latch_r, pe_latch_r};
    poe_all   = {{`GPEF_PF_W{1'b0}}, periph_oe_e};
    pout_all  = {{`GPEF_PF_W{1'b0}}, periph_out_e};
    seg_all   = {{`GPEF_PF_W{1'b0}}, seg_sel_r & {8{port_input_control_r}}};
    segv_all  = {{`GPEF_PF_W{1'b0}}, lcd_seg_out};
    claim_all = {PF2_RESET_ONLY, main_osc_en, main_osc_en, 8'h00};
    blk_all   = {{`GPEF_PF_W{1'b0}}, {8{!port_input_control_r}}};
  end

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pin
      localparam bit OD = OD_ALL[gi];
      gpef_pin_cell #(
        .OPEN_DRAIN (OD)
      ) u_cell_n (
        .dir        (dir_all[gi]),
        .latch      (latch_all[gi]),
        .periph_oe  (poe_all[gi]),
        .periph_out (pout_all[gi]),
        .seg_en     (seg_all[gi]),
        .seg_out    (segv_all[gi]),
        .claim      (claim_all[gi]),
        .in_block   (blk_all[gi]),
        .isolate    (isolate),
        .pin_in     (pin_sync[gi]),
        .read_modify_write        (rmw_rd),
        .pin_o      (cell_o[gi]),
        .pin_oe     (cell_oe[gi]),
        .rd         (cell_rd[gi])
      );
    end
  endgenerate

  // ========================================================================
  // pin output registers
  always_comb begin
    pin_o_nxt  = cell_o;
    pin_oe_nxt = cell_oe;
    if (hold) begin
      pin_o_nxt  = pin_o_r;
      pin_oe_nxt = pin_oe_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_o_r  <= '0;
      pin_oe_r <= '0;
    end else begin
      pin_o_r  <= pin_o_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  assign pe_o  = pin_o_r[`GPEF_PE_W-1:0];
  assign pe_oe = pin_oe_r[`GPEF_PE_W-1:0];
  assign pf_o  = pin_o_r[NP-1:`GPEF_PE_W];
  assign pf_oe = pin_oe_r[NP-1:`GPEF_PE_W];

  // ========================================================================
  // write channel
  logic                   do_write;
  logic [`GPEF_ADDR_W-1:0] wa;

  assign s_axi_awready = !aw_held_r && (wst_r == GPEF_WS_IDLE);
  assign s_axi_wready  = !w_held_r && (wst_r == GPEF_WS_IDLE);
  assign s_axi_bvalid  = (wst_r == GPEF_WS_RESP);
  assign s_axi_bresp   = bresp_r;
  assign do_write      = aw_held_r && w_held_r;
  assign wa            = {waddr_r[`GPEF_ADDR_W-1:2], 2'h0};

  always_comb begin
    wst_nxt      = wst_r;
    aw_held_nxt  = aw_held_r;
    w_held_nxt   = w_held_r;
    waddr_nxt    = waddr_r;
    wdata_nxt    = wdata_r;
    wstb_nxt     = wstb_r;
    bresp_nxt    = bresp_r;
    pe_latch_nxt = pe_latch_r;
    pe_dir_nxt   = pe_dir_r;
    pf_latch_nxt = pf_latch_r;
    pf_dir_nxt   = pf_dir_r;
    spl_nxt      = spl_r;
    seg_sel_nxt  = seg_sel_r;
    port_input_control_nxt    = port_input_control_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      waddr_nxt   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstb_nxt   = s_axi_wstrb[1:0];
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      wst_nxt     = GPEF_WS_RESP;
      bresp_nxt   = `GPEF_RESP_OKAY;
      case (wa)
        `GPEF_OFF_PE_LATCH: if (wstb_r[0]) pe_latch_nxt = wdata_r[7:0];
        `GPEF_OFF_PE_DIR:   if (wstb_r[0]) pe_dir_nxt = wdata_r[7:0];
        `GPEF_OFF_PF_LATCH: begin
          if (wstb_r[0]) pf_latch_nxt = wdata_r[`GPEF_PF_W-1:0];
        end
        `GPEF_OFF_PF_DIR: begin
          if (wstb_r[0]) pf_dir_nxt = wdata_r[`GPEF_PF_W-1:0];
        end
        `GPEF_OFF_STANDBY:  if (wstb_r[0]) spl_nxt = wdata_r[`GPEF_SPL_BIT];
        `GPEF_OFF_LCD_SEL: begin
          if (wstb_r[0]) seg_sel_nxt = wdata_r[7:0];
          if (|wstb_r) port_input_control_nxt = wdata_r[`GPEF_PORT_INPUT_CONTROL_BIT];
        end
        `GPEF_OFF_STATUS, `GPEF_OFF_PE_RMW, `GPEF_OFF_PF_RMW: begin
          bresp_nxt = `GPEF_RESP_OKAY;
        end
        default: bresp_nxt = `GPEF_RESP_SLVERR;
      endcase
    end
    if (wst_r == GPEF_WS_RESP && s_axi_bready) begin
      wst_nxt = GPEF_WS_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r      <= GPEF_WS_IDLE;
      aw_held_r  <= 1'b0;
      w_held_r   <= 1'b0;
      waddr_r    <= '0;
      wdata_r    <= '0;
      wstb_r     <= 2'h0;
      bresp_r    <= `GPEF_RESP_OKAY;
      pe_latch_r <= `GPEF_RST_LATCH_E;
      pe_dir_r   <= `GPEF_RST_DIR_E;
      pf_latch_r <= `GPEF_RST_LATCH_F;
      pf_dir_r   <= `GPEF_RST_DIR_F;
      spl_r      <= 1'b0;
      seg_sel_r  <= `GPEF_RST_SEG;
      port_input_control_r    <= 1'b0;
    end else begin
      wst_r      <= wst_nxt;
      aw_held_r  <= aw_held_nxt;
      w_held_r   <= w_held_nxt;
      waddr_r    <= waddr_nxt;
      wdata_r    <= wdata_nxt;
      wstb_r     <= wstb_nxt;
      bresp_r    <= bresp_nxt;
      pe_latch_r <= pe_latch_nxt;
      pe_dir_r   <= pe_dir_nxt;
      pf_latch_r <= pf_latch_nxt;
      pf_dir_r   <= pf_dir_nxt;
      spl_r      <= spl_nxt;
      seg_sel_r  <= seg_sel_nxt;
      port_input_control_r    <= port_input_control_nxt;
    end
  end

  // ========================================================================
  // read channel
  logic [`GPEF_ADDR_W-1:0] ra;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign ra            = {s_axi_araddr[`GPEF_ADDR_W-1:2], 2'h0};
  assign rmw_rd        = (ra == `GPEF_OFF_PE_RMW) || (ra == `GPEF_OFF_PF_RMW);

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `GPEF_RESP_OKAY;
      rdata_nxt  = '0;
      case (ra)
        `GPEF_OFF_PE_LATCH, `GPEF_OFF_PE_RMW: begin
          rdata_nxt[7:0] = cell_rd[7:0];
        end
        `GPEF_OFF_PE_DIR:   rdata_nxt[7:0] = pe_dir_r;
        `GPEF_OFF_PF_LATCH, `GPEF_OFF_PF_RMW: begin
          rdata_nxt[`GPEF_PF_W-1:0] = cell_rd[NP-1:`GPEF_PE_W];
        end
        `GPEF_OFF_PF_DIR:   rdata_nxt[`GPEF_PF_W-1:0] = pf_dir_r;
        `GPEF_OFF_STANDBY:  rdata_nxt[`GPEF_SPL_BIT] = spl_r;
        `GPEF_OFF_LCD_SEL: begin
          rdata_nxt[7:0]             = seg_sel_r;
          rdata_nxt[`GPEF_PORT_INPUT_CONTROL_BIT] = port_input_control_r;
        end
        `GPEF_OFF_STATUS: begin
          rdata_nxt[NP-1:0]             = pin_sync;
          rdata_nxt[`GPEF_STS_STBY_BIT] = standby_req;
        end
        default: rresp_nxt = `GPEF_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= `GPEF_RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end
endmodule

// [dv/gpef_port_asserts.sv]
`timescale 1ns/1ps
`include "gpef_params.svh"
// ==========================================================
// port checker
module gpef_port_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  pe_oe,
  input wire logic [2:0]  pf_o,
  input wire logic [2:0]  pf_oe
);
  logic [7:0] ra_r;
  logic [7:0] wa_r;

  // ==========================================================
  // address capture
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra_r <= s_axi_araddr;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      wa_r <= s_axi_awaddr;
    end
  end

  function automatic logic mapped(logic [7:0] a);
    return (a & 8'hfc) inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                               8'h18, 8'h20, 8'h28};
  endfunction

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // assertions
  a_rst_no_drive: assert property (disable iff (1'b0)
    !aresetn |=> pe_oe == 8'h00 && pf_oe == 3'h0)
    else $error("pins driven after reset");
  a_od_low_only: assert property (
    pf_oe[2] |-> !pf_o[2]) else $error("open drain pin driven high");
  a_pf_upper_zero: assert property (
    $rose(s_axi_rvalid) && ra_r inside {8'h08, 8'h0c, 8'h28}
    |-> s_axi_rdata[31:3] == 29'h0) else $error("port f upper bits set");
  a_rd_answer_time: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer_time: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer time");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while busy");
  a_bad_wr_err: assert property (
    $rose(s_axi_bvalid) && !mapped(wa_r) |-> s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  a_bad_rd_err: assert property (
    $rose(s_axi_rvalid) && !mapped(ra_r)
    |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

bind gpef_port gpef_port_asserts i_chk (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .pe_oe, .pf_o, .pf_oe);

// [dv/gpef_pins_model.sv]
`timescale 1ns/1ps
// ==========================================================
// board pins: driven bit wins, else the board level
module gpef_pins_model (
  input  wire logic [7:0] pe_o,
  input  wire logic [7:0] pe_oe,
  input  wire logic [7:0] ext_e,
  input  wire logic [2:0] pf_o,
  input  wire logic [2:0] pf_oe,
  input  wire logic [2:0] ext_f,
  output logic      [7:0] pe_i,
  output logic      [2:0] pf_i
);
  assign pe_i = (pe_oe & pe_o) | (~pe_oe & ext_e);
  assign pf_i = (pf_oe & pf_o) | (~pf_oe & ext_f);
endmodule

// [dv/test_gpef_port.sv]
`timescale 1ns/1ps
`include "gpef_params.svh"
module test_gpef_port;
  import gpef_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, standby_req = 1'b0, main_osc_en = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  gpef_byte_t periph_oe_e = 8'h00, periph_out_e = 8'h00;
  gpef_byte_t lcd_seg_out = 8'h00, ext_e = 8'h00;
  logic [7:0] pe_i, pe_o, pe_oe;
  logic [2:0] pf_i, pf_o, pf_oe, ext_f = 3'h7;
  int n_errors = 0;
  int total_checks = 0;

  always #50 aclk = ~aclk;

  gpef_port i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .standby_req, .periph_oe_e, .periph_out_e, .lcd_seg_out,
    .main_osc_en, .pe_i, .pe_o, .pe_oe, .pf_i, .pf_o, .pf_oe);
  gpef_pins_model i_pins (.pe_o, .pe_oe, .ext_e, .pf_o, .pf_oe, .ext_f,
    .pe_i, .pf_i);

  // ==========================================================
  // checking and closing
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic settle();
    repeat (4) @(posedge aclk);
  endtask

  // ==========================================================
  // bus tasks
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    logic tb;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(posedge aclk);
      tb = s_axi_bvalid;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (tb) check("bresp", 32'(s_axi_bresp), 32'(er));
      if (tb) s_axi_bready <= 1'b0;
    end
    if (!tb) begin
      check("write timeout", 32'h0, 32'h1);
      complete_run();
    end
  endtask

  task automatic rdc(logic [7:0] a, logic [31:0] e, logic [1:0] er = 2'h0);
    logic tr;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && !tr; n++) begin
      @(posedge aclk);
      tr = s_axi_rvalid;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (tr) check($sformatf("rdata %h", a), s_axi_rdata, e);
      if (tr) check("rresp", 32'(s_axi_rresp), 32'(er));
      if (tr) s_axi_rready <= 1'b0;
    end
    if (!tr) begin
      check("read timeout", 32'h0, 32'h1);
      complete_run();
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    check("pe_oe", 32'(pe_oe), 32'h0);
    rdc(`GPEF_OFF_PE_DIR, 32'h0);
    rdc(`GPEF_OFF_PF_DIR, 32'h0);
    ext_e <= 8'h5a;
    wr(`GPEF_OFF_LCD_SEL, 32'h100, 2'h0);
    wr(`GPEF_OFF_PE_LATCH, 32'ha5, 2'h0);
    settle();
    check("pe_oe", 32'(pe_oe), 32'h0);
    rdc(`GPEF_OFF_PE_LATCH, 32'h5a);
    rdc(`GPEF_OFF_PE_RMW, 32'ha5);
    wr(`GPEF_OFF_PE_DIR, 32'hff, 2'h0);
    settle();
    check("pe_oe", 32'(pe_oe), 32'hff);
    check("pe_o", 32'(pe_o), 32'ha5);
    rdc(`GPEF_OFF_PE_LATCH, 32'ha5);
    wr(`GPEF_OFF_PE_LATCH, 32'h3c, 2'h0);
    settle();
    check("pe_o", 32'(pe_o), 32'h3c);
    periph_out_e <= 8'h40;
    periph_oe_e <= 8'h60;
    settle();
    check("pe_o", 32'(pe_o & 8'h60), 32'h40);
    rdc(`GPEF_OFF_PE_LATCH, 32'h5c);
    rdc(`GPEF_OFF_PE_RMW, 32'h3c);
    periph_oe_e <= 8'h00;
    wr(`GPEF_OFF_PE_DIR, 32'h0, 2'h0);
    lcd_seg_out <= 8'h01;
    wr(`GPEF_OFF_LCD_SEL, 32'h103, 2'h0);
    settle();
    check("pe_oe", 32'(pe_oe), 32'h03);
    check("pe_o", 32'(pe_o & 8'h03), 32'h01);
    wr(`GPEF_OFF_LCD_SEL, 32'h100, 2'h0);
    wr(`GPEF_OFF_PF_DIR, 32'hff, 2'h0);
    rdc(`GPEF_OFF_PF_DIR, 32'h7);
    wr(`GPEF_OFF_PF_LATCH, 32'hff, 2'h0);
    settle();
    check("pf_oe", 32'(pf_oe), 32'h3);
    rdc(`GPEF_OFF_PF_LATCH, 32'h7);
    wr(`GPEF_OFF_PF_LATCH, 32'h2, 2'h0);
    settle();
    check("pf_oe", 32'(pf_oe), 32'h7);
    check("pf_o", 32'(pf_o), 32'h2);
    main_osc_en <= 1'b1;
    settle();
    check("pf_oe", 32'(pf_oe), 32'h4);
    main_osc_en <= 1'b0;
    wr(8'h30, 32'hff, `GPEF_RESP_SLVERR);
    rdc(8'h30, 32'h0, `GPEF_RESP_SLVERR);
    wr(`GPEF_OFF_PE_DIR, 32'h0, 2'h0);
    wr(`GPEF_OFF_STANDBY, 32'h1, 2'h0);
    standby_req <= 1'b1;
    settle();
    check("pe_oe", 32'(pe_oe), 32'h0);
    check("pf_oe", 32'(pf_oe), 32'h0);
    rdc(`GPEF_OFF_PE_LATCH, 32'h0);
    standby_req <= 1'b0;
    wr(`GPEF_OFF_PE_DIR, 32'hff, 2'h0);
    wr(`GPEF_OFF_STANDBY, 32'h0, 2'h0);
    standby_req <= 1'b1;
    wr(`GPEF_OFF_PE_LATCH, 32'hc3, 2'h0);
    settle();
    check("pe_o", 32'(pe_o), 32'h3c);
    check("pe_oe", 32'(pe_oe), 32'hff);
    standby_req <= 1'b0;
    settle();
    check("pe_o", 32'(pe_o), 32'hc3);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check("pe_oe", 32'(pe_oe), 32'h0);
    rdc(`GPEF_OFF_PE_DIR, 32'h0);
    complete_run();
  end
endmodule
